// >>> include/usm_pkg.sv
package usm_pkg;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_LINE_FORMAT_CONFIG = 8'h04;
  localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h08;
  localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h0C;
  localparam logic [7:0] OFF_IRQ_ENABLE_STATE = 8'h10;
  localparam logic [7:0] OFF_CHANNEL_STATE = 8'h14;
  localparam logic [7:0] OFF_RX_HOLDING_REG = 8'h18;
  localparam logic [7:0] OFF_TX_HOLDING_REG = 8'h1C;
  // control register command bits
  localparam int CMD_RX_RESET = 2;
  localparam int CMD_TX_RESET = 3;
  localparam int CMD_RX_ON = 4;
  localparam int CMD_RX_OFF = 5;
  localparam int CMD_TX_ON = 6;
  localparam int CMD_TX_OFF = 7;
  localparam int CMD_CLEAR_ERROR_FLAGS = 8;
  localparam int CMD_BEGIN_BREAK = 9;
  localparam int CMD_END_BREAK = 10;
  localparam int CMD_CLEAR_ITERATION = 13;
  localparam int CMD_CLEAR_NON_ACK = 14;
  // line_format_config fields
  localparam int LF_MODE_LSB = 0;
  localparam int LF_CLKSRC_LSB = 4;
  localparam int LF_CHARLEN_LSB = 6;
  localparam int LF_SYNC = 8;
  localparam int LF_PARITY_LSB = 9;
  localparam int LF_STOP_LSB = 12;
  localparam int LF_TESTMODE_LSB = 14;
  localparam int LF_MSB_FIRST = 16;
  localparam int LF_NINE_BIT = 17;
  localparam int LF_CLK_OUT = 18;
  localparam int LF_OVERSAMPLE8 = 19;
  localparam int LF_INHIBIT_NON_ACK_SEEN = 20;
  localparam int LF_SUCC_NON_ACK_SEEN_LIM = 21;
  localparam int LF_MAX_ITER_LSB = 24;
  localparam int LF_IR_FILTER = 28;
  localparam logic [31:0] LF_WRITE_MASK = 32'h173F_FFFF;
  localparam logic [31:0] LF_RESET = 32'h0000_0000;
  // status bit positions, shared by mask and channel_state
  localparam int ST_RX_CHAR_READY = 0;
  localparam int ST_TX_HOLDING_FREE = 1;
  localparam int ST_RX_BREAK_EVENT = 2;
  localparam int ST_RX_DMA_DONE = 3;
  localparam int ST_TX_DMA_DONE = 4;
  localparam int ST_OVERRUN_ERROR = 5;
  localparam int ST_FRAMING_ERROR = 6;
  localparam int ST_PARITY_ERROR = 7;
  localparam int ST_RX_TIMEOUT = 8;
  localparam int ST_TX_FULLY_DRAINED = 9;
  localparam int ST_ITERATION_HIT = 10;
  localparam int ST_TX_DMA_BUF_EMPTY = 11;
  localparam int ST_RX_DMA_BUF_FULL = 12;
  localparam int ST_NON_ACK_SEEN = 13;
  localparam int ST_CHANGE_LSB = 16;
  localparam int ST_IMAGE_LSB = 20;
  localparam logic [31:0] IRQ_SRC_MASK = 32'h000F_3FFF;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  // field encodings
  localparam logic [1:0] TM_NORMAL = 2'h0;
  localparam logic [1:0] TM_ECHO = 2'h1;
  localparam logic [1:0] TM_LOCAL_LOOP = 2'h2;
  localparam logic [1:0] TM_REMOTE_LOOP = 2'h3;
  localparam logic [1:0] CLKSRC_EXTERNAL = 2'h3;
  localparam logic [3:0] MODE_SMART_T0 = 4'h4;
  localparam logic [1:0] STOP_ONE = 2'h0;
  localparam logic [1:0] STOP_ONE_HALF = 2'h1;
  localparam logic [1:0] STOP_TWO = 2'h2;
  localparam logic [2:0] HALF_BITS_ONE = 3'h2;
  localparam logic [2:0] HALF_BITS_ONE_HALF = 3'h3;
  localparam logic [2:0] HALF_BITS_TWO = 3'h4;
  localparam logic [3:0] CHAR_BITS_BASE = 4'h5;
  localparam logic [3:0] CHAR_BITS_NINE = 4'h9;
  localparam logic [4:0] SAMPLES_16 = 5'h10;
  localparam logic [4:0] SAMPLES_8 = 5'h08;

  typedef struct packed {
    logic done;
    logic parityErr;
    logic frameErr;
    logic breakEvt;
    logic [8:0] data;
  } usm_rx_evt_t;

  typedef struct packed {
    logic ri;
    logic dsr;
    logic dcd;
    logic cts;
  } usm_modem_t;

  typedef struct packed {
    logic rxTimeout;
    logic txDrained;
    logic rxDmaDone;
    logic txDmaDone;
    logic txDmaBufEmpty;
    logic rxDmaBufFull;
    logic nonAckSeen;
  } usm_side_t;

  typedef struct packed {
    logic [3:0] mode;
    logic [1:0] clockSourceSel;
    logic [2:0] parity;
    logic syncMode;
    logic [2:0] stopHalfBits;
    logic stopReserved;
    logic msbFirst;
    logic [3:0] charBits;
    logic [4:0] samplesPerBit;
    logic rxEnable;
    logic txEnable;
    logic breakReq;
  } usm_cfg_t;
endpackage : usm_pkg

// >>> rtl/usm_status_core.sv
// How it works
// (R1) stop-bit field picks 1, 1.5, 2 stops
// (R2) echo mode copies receiver input to transmit pin
// (R3) local loopback feeds transmitter into receiver
// (R4) remote loopback ties receive pin to transmit pin
// (R5) bit-order flag selects lsb or msb first
// (R6) nine-bit flag overrides character length field
// (R7) clock pin driven only if enabled, internal source
// (R8) oversampling flag picks 16 or 8 samples
// (R9) inhibit flag suppresses every non-acknowledge
// (R10) parity error sends immediate non-acknowledge
// (R11) limited mode counts errors, acks each counted
// (R12) limit reached stops acks, sets iteration flag
// (R13) iteration-limit field holds maximum repetitions
// (R14) filter flag enables 2-of-3 majority vote
// (R15) enable-set write of 1 sets mask bit
// (R16) enable-clear write of 1 clears mask bit
// (R17) mask state reads enabled sources, status positions
// (R18) rx ready set on char, cleared by read/disable
// (R19) chars seen while disabled raise ready on enable
// (R20) tx free low when full, break, or disabled
// (R21) tx free rises as soon as enabled
// (R22) break flag sticky until error-clear command
// (R23) error-clear command clears parity, frame, overrun, break
// (R24) modem change flags: edge sets, status read clears
// (R25) interrupt when any status bit and mask bit
//
// The register offsets and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module usm_status_core
  import usm_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rxdPin,
  output logic txdPin,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic sampleTick,
  input wire logic txShiftBit,
  input wire logic txTake,
  output logic [8:0] txHoldData,
  output logic txHoldValid,
  output logic rxLine,
  input wire usm_rx_evt_t rxEvt,
  input wire usm_modem_t modemIn,
  input wire usm_side_t sideIn,
  input wire logic baudClk,
  output usm_cfg_t cfgOut,
  output logic nackReq,
  output logic irq
);
  logic [31:0] lineCfg_q, lineCfg_d;
  logic [31:0] mask_q, mask_d;
  logic rxEn_q, rxEn_d, txEn_q, txEn_d;
  logic rxReady_q, rxReady_d, rxPend_q, rxPend_d;
  logic [8:0] rxHold_q, rxHold_d;
  logic holdFull_q, holdFull_d;
  logic [8:0] txHold_q, txHold_d;
  logic breakReq_q, breakReq_d;
  logic brk_q, brk_d, ovr_q, ovr_d, frm_q, frm_d, par_q, par_d;
  logic iterHit_q, iterHit_d, nackFlag_q, nackFlag_d;
  logic [2:0] iterCnt_q, iterCnt_d;
  logic non_ack_seen_q, non_ack_seen_d;
  logic [3:0] chg_q, chg_d, modemPrev_q, modemPrev_d;
  logic primed_q, primed_d;
  logic [2:0] samp_q, samp_d;
  logic txd_q, txd_d, rxLine_q, rxLine_d, sck_q, sck_d;
  logic access, wrAcc, rdAcc, mapped;
  logic [31:0] ctrlWr, status;
  logic [1:0] testMode;
  logic [2:0] maxIter;
  logic majority, rxSel, txFree, smartCard;

  // apb decode; every access completes in its first access cycle
  assign access = psel && penable;
  assign wrAcc = access && pwrite;
  assign rdAcc = access && !pwrite;
  assign pready = 1'b1;
  assign testMode = lineCfg_q[LF_TESTMODE_LSB +: 2];
  assign maxIter = lineCfg_q[LF_MAX_ITER_LSB +: 3]; // [R13]
  assign smartCard = lineCfg_q[LF_MODE_LSB +: 4] == MODE_SMART_T0;
  assign ctrlWr = (wrAcc && paddr == OFF_CTRL) ? pwdata : 32'h0000_0000;

  // address map check; wrong direction on a one-way register also errs
  always_comb begin
    case (paddr)
      OFF_CTRL, OFF_IRQ_ENABLE_SET, OFF_IRQ_ENABLE_CLEAR, OFF_TX_HOLDING_REG: mapped = pwrite;
      OFF_IRQ_ENABLE_STATE, OFF_CHANNEL_STATE, OFF_RX_HOLDING_REG: mapped = !pwrite;
      OFF_LINE_FORMAT_CONFIG: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end
  assign pslverr = access && !mapped;

  // status word, same bit positions as the mask
  assign txFree = txEn_q && !holdFull_q && !breakReq_q; // [R20] [R21]
  always_comb begin
    status = 32'h0000_0000;
    status[ST_RX_CHAR_READY] = rxReady_q;
    status[ST_TX_HOLDING_FREE] = txFree;
    status[ST_RX_BREAK_EVENT] = brk_q;
    status[ST_RX_DMA_DONE] = sideIn.rxDmaDone;
    status[ST_TX_DMA_DONE] = sideIn.txDmaDone;
    status[ST_OVERRUN_ERROR] = ovr_q;
    status[ST_FRAMING_ERROR] = frm_q;
    status[ST_PARITY_ERROR] = par_q;
    status[ST_RX_TIMEOUT] = sideIn.rxTimeout;
    status[ST_TX_FULLY_DRAINED] = sideIn.txDrained;
    status[ST_ITERATION_HIT] = iterHit_q;
    status[ST_TX_DMA_BUF_EMPTY] = sideIn.txDmaBufEmpty;
    status[ST_RX_DMA_BUF_FULL] = sideIn.rxDmaBufFull;
    status[ST_NON_ACK_SEEN] = nackFlag_q;
    status[ST_CHANGE_LSB +: 4] = {chg_q[0], chg_q[1], chg_q[2], chg_q[3]};
    status[ST_IMAGE_LSB +: 4] = {modemIn.cts, modemIn.dcd, modemIn.dsr, modemIn.ri};
  end

  // read mux; reads of write-only or unmapped space return zero
  always_comb begin
    prdata = 32'h0000_0000;
    if (rdAcc) begin
      case (paddr)
        OFF_LINE_FORMAT_CONFIG: prdata = lineCfg_q;
        OFF_IRQ_ENABLE_STATE: prdata = mask_q; // [R17]
        OFF_CHANNEL_STATE: prdata = status;
        OFF_RX_HOLDING_REG: prdata = {23'h000000, rxHold_q};
        default: prdata = 32'h0000_0000;
      endcase
    end
  end

  assign irq = |(status & mask_q & IRQ_SRC_MASK); // [R25]

  // receive line: three-sample majority on the sixteenth-bit tick
  assign majority = (samp_q[0] & samp_q[1]) | (samp_q[1] & samp_q[2]) | (samp_q[0] & samp_q[2]);
  always_comb begin
    if (testMode == TM_LOCAL_LOOP) begin
      rxSel = txShiftBit; // [R3]
    end else if (lineCfg_q[LF_IR_FILTER]) begin
      rxSel = majority; // [R14]
    end else begin
      rxSel = rxdPin;
    end
  end

  // next-state logic for every register of the block except the transmit pin register
  always_comb begin
    lineCfg_d = lineCfg_q;
    mask_d = mask_q;
    rxEn_d = rxEn_q;
    txEn_d = txEn_q;
    rxReady_d = rxReady_q;
    rxPend_d = rxPend_q;
    rxHold_d = rxHold_q;
    holdFull_d = holdFull_q;
    txHold_d = txHold_q;
    breakReq_d = breakReq_q;
    brk_d = brk_q;
    ovr_d = ovr_q;
    frm_d = frm_q;
    par_d = par_q;
    iterHit_d = iterHit_q;
    nackFlag_d = nackFlag_q;
    iterCnt_d = iterCnt_q;
    non_ack_seen_d = 1'b0;
    chg_d = chg_q;
    modemPrev_d = modemIn;
    primed_d = 1'b1;
    samp_d = sampleTick ? {samp_q[1:0], rxdPin} : samp_q;
    rxLine_d = rxSel;
    sck_d = baudClk;

    if (wrAcc && paddr == OFF_LINE_FORMAT_CONFIG) begin
      lineCfg_d = pwdata & LF_WRITE_MASK;
    end
    // mask: set and clear registers, ones act, zeros leave alone
    if (wrAcc && paddr == OFF_IRQ_ENABLE_SET) begin
      mask_d = mask_q | (pwdata & IRQ_SRC_MASK); // [R15]
    end
    if (wrAcc && paddr == OFF_IRQ_ENABLE_CLEAR) begin
      mask_d = mask_q & ~pwdata; // [R16]
    end

    // receiver enable: disable wins over enable in the same write
    if (ctrlWr[CMD_RX_OFF] || ctrlWr[CMD_RX_RESET]) begin
      rxEn_d = 1'b0;
    end else if (ctrlWr[CMD_RX_ON]) begin
      rxEn_d = 1'b1;
    end
    if (ctrlWr[CMD_TX_OFF] || ctrlWr[CMD_TX_RESET]) begin
      txEn_d = 1'b0;
    end else if (ctrlWr[CMD_TX_ON]) begin
      txEn_d = 1'b1;
    end

    // rx ready: holding-register read clears, a new char (set) wins
    if (rdAcc && paddr == OFF_RX_HOLDING_REG) begin
      rxReady_d = 1'b0; // [R18]
    end
    if (rxEvt.done) begin
      if (rxEn_q) begin
        if (rxReady_q && !(rdAcc && paddr == OFF_RX_HOLDING_REG)) begin
          ovr_d = 1'b1;
        end
        rxReady_d = 1'b1; // [R18]
        rxHold_d = rxEvt.data;
      end else begin
        rxPend_d = 1'b1;
      end
    end
    if (!rxEn_q) begin
      rxReady_d = 1'b0; // [R18]
      if (rxEn_d && (rxPend_q || rxEvt.done)) begin
        rxReady_d = 1'b1; // [R19]
        rxPend_d = 1'b0;
      end
    end
    if (ctrlWr[CMD_RX_RESET]) begin
      rxPend_d = 1'b0;
    end

    // tx holding register; a write in the take cycle keeps it full
    if (txTake) begin
      holdFull_d = 1'b0;
    end
    if (wrAcc && paddr == OFF_TX_HOLDING_REG && txEn_q) begin
      holdFull_d = 1'b1;
      txHold_d = pwdata[8:0];
    end
    if (ctrlWr[CMD_BEGIN_BREAK] && txEn_q) begin
      breakReq_d = 1'b1; // [R20]
    end else if (ctrlWr[CMD_END_BREAK]) begin
      breakReq_d = 1'b0;
    end
    if (ctrlWr[CMD_TX_RESET]) begin
      holdFull_d = 1'b0;
      breakReq_d = 1'b0;
    end

    // error flags: clear command first, so events in the same cycle win
    if (ctrlWr[CMD_CLEAR_ERROR_FLAGS]) begin
      brk_d = 1'b0; // [R23]
      ovr_d = 1'b0;
      frm_d = 1'b0;
      par_d = 1'b0;
    end
    if (rxEvt.done && rxEn_q && rxReady_q && !(rdAcc && paddr == OFF_RX_HOLDING_REG)) begin
      ovr_d = 1'b1;
    end
    if (rxEvt.breakEvt) begin
      brk_d = 1'b1; // [R22]
    end
    if (rxEvt.done && rxEvt.frameErr) begin
      frm_d = 1'b1;
    end
    if (rxEvt.done && rxEvt.parityErr) begin
      par_d = 1'b1;
    end

    // smart-card non-acknowledge and repetition limit
    if (ctrlWr[CMD_CLEAR_ITERATION] && smartCard) begin
      iterHit_d = 1'b0;
      iterCnt_d = 3'h0;
    end
    if (ctrlWr[CMD_CLEAR_NON_ACK]) begin
      nackFlag_d = 1'b0;
    end
    if (sideIn.nonAckSeen) begin
      nackFlag_d = 1'b1;
    end
    if (smartCard && rxEvt.done && rxEn_q) begin
      if (!rxEvt.parityErr) begin
        iterCnt_d = 3'h0; // a good char ends the run of errors
      end else if (!lineCfg_q[LF_SUCC_NON_ACK_SEEN_LIM]) begin
        non_ack_seen_d = !lineCfg_q[LF_INHIBIT_NON_ACK_SEEN]; // [R10] [R9]
      end else if (iterCnt_q < maxIter) begin
        non_ack_seen_d = !lineCfg_q[LF_INHIBIT_NON_ACK_SEEN]; // [R11] [R9]
        iterCnt_d = iterCnt_q + 3'h1;
        if (iterCnt_q + 3'h1 == maxIter) begin
          iterHit_d = 1'b1; // [R12]
        end
      end else begin
        iterHit_d = 1'b1; // [R12]
      end
    end

    // modem change flags: status read clears, an edge in that cycle wins
    if (rdAcc && paddr == OFF_CHANNEL_STATE) begin
      chg_d = 4'h0; // [R24]
    end
    if (primed_q) begin
      chg_d = chg_d | (modemIn ^ modemPrev_q); // [R24]
    end
  end

  // transmit pin source per test mode; registered for a clean pin
  always_comb begin
    case (testMode)
      TM_ECHO: txd_d = rxSel; // [R2]
      TM_LOCAL_LOOP: txd_d = 1'b1; // idle high while looped inside [R3]
      TM_REMOTE_LOOP: txd_d = rxdPin; // [R4]
      default: txd_d = breakReq_q ? 1'b0 : txShiftBit;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lineCfg_q <= LF_RESET;
      mask_q <= MASK_RESET;
      rxEn_q <= 1'b0;
      txEn_q <= 1'b0;
      rxReady_q <= 1'b0;
      rxPend_q <= 1'b0;
      rxHold_q <= 9'h000;
      holdFull_q <= 1'b0;
      txHold_q <= 9'h000;
      breakReq_q <= 1'b0;
      brk_q <= 1'b0;
      ovr_q <= 1'b0;
      frm_q <= 1'b0;
      par_q <= 1'b0;
      iterHit_q <= 1'b0;
      nackFlag_q <= 1'b0;
      iterCnt_q <= 3'h0;
      non_ack_seen_q <= 1'b0;
      chg_q <= 4'h0;
      modemPrev_q <= 4'h0;
      primed_q <= 1'b0;
      samp_q <= 3'h7;
      txd_q <= 1'b1;
      rxLine_q <= 1'b1;
      sck_q <= 1'b0;
    end else begin
      lineCfg_q <= lineCfg_d;
      mask_q <= mask_d;
      rxEn_q <= rxEn_d;
      txEn_q <= txEn_d;
      rxReady_q <= rxReady_d;
      rxPend_q <= rxPend_d;
      rxHold_q <= rxHold_d;
      holdFull_q <= holdFull_d;
      txHold_q <= txHold_d;
      breakReq_q <= breakReq_d;
      brk_q <= brk_d;
      ovr_q <= ovr_d;
      frm_q <= frm_d;
      par_q <= par_d;
      iterHit_q <= iterHit_d;
      nackFlag_q <= nackFlag_d;
      iterCnt_q <= iterCnt_d;
      non_ack_seen_q <= non_ack_seen_d;
      chg_q <= chg_d;
      modemPrev_q <= modemPrev_d;
      primed_q <= primed_d;
      samp_q <= samp_d;
      txd_q <= txd_d;
      rxLine_q <= rxLine_d;
      sck_q <= sck_d;
    end
  end

  // configuration decode for the neighbouring shifters
  always_comb begin
    cfgOut.mode = lineCfg_q[LF_MODE_LSB +: 4];
    cfgOut.clockSourceSel = lineCfg_q[LF_CLKSRC_LSB +: 2];
    cfgOut.parity = lineCfg_q[LF_PARITY_LSB +: 3];
    cfgOut.syncMode = lineCfg_q[LF_SYNC];
    cfgOut.msbFirst = lineCfg_q[LF_MSB_FIRST]; // [R5]
    cfgOut.samplesPerBit = lineCfg_q[LF_OVERSAMPLE8] ? SAMPLES_8 : SAMPLES_16; // [R8]
    cfgOut.rxEnable = rxEn_q;
    cfgOut.txEnable = txEn_q;
    cfgOut.breakReq = breakReq_q;
    // [R6]
    if (lineCfg_q[LF_NINE_BIT]) begin
      cfgOut.charBits = CHAR_BITS_NINE;
    end else begin
      cfgOut.charBits = CHAR_BITS_BASE + {2'h0, lineCfg_q[LF_CHARLEN_LSB +: 2]};
    end
    // reserved codes fall back to one stop bit but are flagged [R1]
    cfgOut.stopReserved = 1'b0;
    case (lineCfg_q[LF_STOP_LSB +: 2])
      STOP_ONE: cfgOut.stopHalfBits = HALF_BITS_ONE;
      STOP_ONE_HALF: begin
        cfgOut.stopHalfBits = lineCfg_q[LF_SYNC] ? HALF_BITS_ONE : HALF_BITS_ONE_HALF;
        cfgOut.stopReserved = lineCfg_q[LF_SYNC];
      end
      STOP_TWO: cfgOut.stopHalfBits = HALF_BITS_TWO;
      default: begin
        cfgOut.stopHalfBits = HALF_BITS_ONE;
        cfgOut.stopReserved = 1'b1;
      end
    endcase
  end

  assign txdPin = txd_q;
  assign rxLine = rxLine_q;
  assign sckOut = sck_q;
  // an external clock source means the partner owns the pin [R7]
  assign sckOe = lineCfg_q[LF_CLK_OUT] && (lineCfg_q[LF_CLKSRC_LSB +: 2] != CLKSRC_EXTERNAL);
  assign txHoldData = txHold_q;
  assign txHoldValid = holdFull_q && !breakReq_q;
  assign nackReq = non_ack_seen_q;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  AST_MASK_SET: assert property (wrAcc && paddr == OFF_IRQ_ENABLE_SET && pwdata[0] // [R15]
    |=> mask_q[0])
    else $error("enable-set write did not set mask bit");
  AST_MASK_CLR: assert property (wrAcc && paddr == OFF_IRQ_ENABLE_CLEAR && pwdata[1] // [R16]
    |=> !mask_q[1])
    else $error("enable-clear write did not clear mask bit");
  AST_MASK_HOLD: assert property (!wrAcc |=> mask_q == $past(mask_q)) // [R17]
    else $error("mask changed without a write");
  AST_RX_READY: assert property (rxEvt.done && rxEn_q && rxEn_d // [R18]
    |=> rxReady_q && rxHold_q == $past(rxEvt.data))
    else $error("received char did not raise ready");
  AST_RX_OFF: assert property (!rxEn_q ##1 !rxEn_q |-> !rxReady_q) // [R18]
    else $error("ready high while receiver disabled");
  AST_TX_ON: assert property (ctrlWr[CMD_TX_ON] && !ctrlWr[CMD_TX_OFF] // [R21]
    && !ctrlWr[CMD_TX_RESET] && !ctrlWr[CMD_BEGIN_BREAK] && !holdFull_q && !breakReq_q
    && !txTake |=> status[ST_TX_HOLDING_FREE])
    else $error("tx free not set on enable");
  AST_BREAK_STICKY: assert property (rxEvt.breakEvt // [R22]
    |=> brk_q ##1 (brk_q || $past(ctrlWr[CMD_CLEAR_ERROR_FLAGS])))
    else $error("break flag lost");
  AST_NON_ACK_SEEN_INHIBIT: assert property (lineCfg_q[LF_INHIBIT_NON_ACK_SEEN] && $stable(lineCfg_q) // [R9]
    |=> !nackReq)
    else $error("non-ack sent while inhibited");
  AST_ITER_LIMIT: assert property (iterHit_q && lineCfg_q[LF_SUCC_NON_ACK_SEEN_LIM] // [R12]
    && iterCnt_q >= maxIter |=> !nackReq)
    else $error("non-ack sent past the limit");
  AST_IRQ: assert property (mask_q[ST_RX_CHAR_READY] && rxReady_q |-> irq) // [R25]
    else $error("interrupt disagrees with status and mask");
  AST_REMOTE: assert property (testMode == TM_REMOTE_LOOP && $stable(testMode) // [R4]
    |=> txdPin == $past(rxdPin))
    else $error("remote loopback not tying pins");
endmodule : usm_status_core

// >>> tb/usm_line_partner.sv
`timescale 1ns/1ps
module usm_line_partner
  import usm_pkg::*;
(
  input wire logic core_clk,
  output logic rxdPin,
  output logic sampleTick,
  output logic txShiftBit,
  output logic txTake,
  output usm_rx_evt_t rxEvt,
  output usm_modem_t modemIn,
  output usm_side_t sideIn,
  output logic baudClk
);
  logic [2:0] divQ = 3'h0;
  // tick and baud clock run off the core clock, real bit timing is not modelled
  always @(posedge core_clk) begin
    divQ <= divQ + 3'h1;
  end
  assign sampleTick = (divQ == 3'h0);
  assign baudClk = divQ[2];
  // idle line high, neighbours quiet
  initial begin
    rxdPin = 1'b1;
    txShiftBit = 1'b1;
    txTake = 1'b0;
    rxEvt = '0;
    modemIn = '0;
    sideIn = '0;
  end
  // one receiver event lasting one cycle, fixed character
  task automatic send(input logic done, input logic pe, input logic brk);
    @(posedge core_clk);
    rxEvt <= {done, pe, 1'b0, brk, 9'h0A5};
    @(posedge core_clk);
    rxEvt <= '0;
  endtask : send
  // transmitter takes the holding register
  task automatic take();
    @(posedge core_clk);
    txTake <= 1'b1;
    @(posedge core_clk);
    txTake <= 1'b0;
  endtask : take
  task automatic line(input logic rxd, input logic shift);
    @(posedge core_clk);
    rxdPin <= rxd;
    txShiftBit <= shift;
  endtask : line
  task automatic flip_cts();
    @(posedge core_clk);
    modemIn.cts <= ~modemIn.cts;
  endtask : flip_cts
endmodule : usm_line_partner

// >>> tb/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import usm_pkg::*;
();
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rd, v;
  logic pready, pslverr, txdPin, sckOut, sckOe, txHoldValid, rxLine, nackReq, irq, err;
  logic rxdPin, sampleTick, txShiftBit, txTake, baudClk;
  logic [8:0] txHoldData;
  logic [1:0] st;
  usm_rx_evt_t rxEvt;
  usm_modem_t modemIn;
  usm_side_t sideIn;
  usm_cfg_t cfgOut;
  int mismatches = 0;
  int total_checks = 0;
  logic [2:0] expHalf [5] = '{HALF_BITS_ONE, HALF_BITS_ONE_HALF, HALF_BITS_TWO,
    HALF_BITS_ONE, HALF_BITS_ONE};
  logic [1:0] tms [3] = '{TM_ECHO, TM_LOCAL_LOOP, TM_REMOTE_LOOP};

  usm_status_core dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .rxdPin, .txdPin, .sckIn(1'b0), .sckOut, .sckOe, .sampleTick,
    .txShiftBit, .txTake, .txHoldData, .txHoldValid, .rxLine, .rxEvt, .modemIn, .sideIn,
    .baudClk, .cfgOut, .nackReq, .irq);
  usm_line_partner partner (.core_clk, .rxdPin, .sampleTick, .txShiftBit, .txTake, .rxEvt,
    .modemIn, .sideIn, .baudClk);

  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // one transfer: setup, then access held until pready at a rising edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      chk("apb_ready", 32'h1, 32'h0);
      print_verdict();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask : rdchk

  task automatic stbit(input string nm, input int idx, input logic exp);
    apb(1'b0, OFF_CHANNEL_STATE, 32'h0000_0000);
    chk(nm, {31'h0, exp}, {31'h0, rd[idx]});
  endtask : stbit

  task automatic cmd(input int b);
    apb(1'b1, OFF_CTRL, 32'h0000_0001 << b);
  endtask : cmd

  task automatic non_ack_seen(input string nm, input logic pe, input logic exp);
    partner.send(1'b1, pe, 1'b0);
    #1;
    chk(nm, {31'h0, exp}, {31'h0, nackReq});
  endtask : non_ack_seen

  initial begin
    repeat (4) @(posedge core_clk);
    rst <= 1'b0;
    rdchk("mask_rst", OFF_IRQ_ENABLE_STATE, MASK_RESET);
    apb(1'b0, 8'h20, 32'h0000_0000);
    chk("unmapped", 32'h1, {31'h0, err});
    // mask set, clear, zero writes leave it
    apb(1'b1, OFF_IRQ_ENABLE_SET, 32'hFFFF_FFFF);
    rdchk("mask_all", OFF_IRQ_ENABLE_STATE, IRQ_SRC_MASK);
    apb(1'b1, OFF_IRQ_ENABLE_CLEAR, 32'h000F_3FFD);
    apb(1'b1, OFF_IRQ_ENABLE_SET, 32'h0000_0000);
    rdchk("mask_left", OFF_IRQ_ENABLE_STATE, 32'h0000_0002);
    chk("irq_off", 32'h0, {31'h0, irq});
    // transmitter free flag against enable, holding data and break
    cmd(CMD_TX_ON);
    #1;
    chk("irq_tx", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_TX_HOLDING_REG, 32'h0000_01A5);
    #1;
    chk("hold_data", 32'h1A5, {23'h0, txHoldData});
    chk("hold_valid", 32'h1, {31'h0, txHoldValid});
    stbit("tx_full", ST_TX_HOLDING_FREE, 1'b0);
    partner.take();
    stbit("tx_taken", ST_TX_HOLDING_FREE, 1'b1);
    cmd(CMD_BEGIN_BREAK);
    stbit("tx_brk", ST_TX_HOLDING_FREE, 1'b0);
    cmd(CMD_END_BREAK);
    cmd(CMD_TX_OFF);
    stbit("tx_off", ST_TX_HOLDING_FREE, 1'b0);
    // char while receiver off shows up on enable
    apb(1'b1, OFF_IRQ_ENABLE_SET, 32'h0000_0001);
    partner.send(1'b1, 1'b0, 1'b0);
    stbit("rx_off", ST_RX_CHAR_READY, 1'b0);
    cmd(CMD_RX_ON);
    #1;
    chk("irq_rx", 32'h1, {31'h0, irq});
    apb(1'b0, OFF_RX_HOLDING_REG, 32'h0000_0000);
    stbit("rx_read", ST_RX_CHAR_READY, 1'b0);
    // sticky error and break flags, cleared together
    partner.send(1'b1, 1'b1, 1'b0);
    partner.send(1'b1, 1'b1, 1'b0);
    partner.send(1'b0, 1'b0, 1'b1);
    stbit("ovr", ST_OVERRUN_ERROR, 1'b1);
    stbit("brk", ST_RX_BREAK_EVENT, 1'b1);
    stbit("brk_held", ST_RX_BREAK_EVENT, 1'b1);
    cmd(CMD_CLEAR_ERROR_FLAGS);
    apb(1'b0, OFF_CHANNEL_STATE, 32'h0000_0000);
    chk("err_clr", 32'h0, rd & 32'h0000_00A4);
    // modem change flag set on edge, cleared by the status read
    partner.flip_cts();
    stbit("cts_chg", ST_CHANGE_LSB + 3, 1'b1);
    stbit("cts_clr", ST_CHANGE_LSB + 3, 1'b0);
    // stop codes, bit order, length, oversampling; last is sync
    for (int i = 0; i < 5; i++) begin
      st = (i == 4) ? 2'h1 : 2'(i);
      v = (32'(st) << LF_STOP_LSB) | (32'(st) << LF_CHARLEN_LSB) | (32'(i / 4) << LF_SYNC)
        | (32'(i % 2) * 32'h000B_0000);
      apb(1'b1, OFF_LINE_FORMAT_CONFIG, v);
      #1;
      chk("stop", {29'h0, expHalf[i]}, {29'h0, cfgOut.stopHalfBits});
      chk("stop_rsv", (i >= 3), {31'h0, cfgOut.stopReserved});
      chk("msb", i % 2, {31'h0, cfgOut.msbFirst});
      chk("chr", (i % 2) ? 32'(CHAR_BITS_NINE) : 32'(CHAR_BITS_BASE) + 32'(st),
        {28'h0, cfgOut.charBits});
      chk("ovs", (i % 2) ? 32'(SAMPLES_8) : 32'(SAMPLES_16), {27'h0, cfgOut.samplesPerBit});
      rdchk("cfg_rd", OFF_LINE_FORMAT_CONFIG, v & LF_WRITE_MASK);
    end
    // clock pin drive: on, external source, off
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, OFF_LINE_FORMAT_CONFIG, (32'(i < 2) << LF_CLK_OUT) | (32'(i % 2) * 32'h30));
      #1;
      chk("sck_oe", (i == 0), {31'h0, sckOe});
    end
    // test modes with both line levels
    for (int i = 0; i < 6; i++) begin
      apb(1'b1, OFF_LINE_FORMAT_CONFIG, 32'(tms[i / 2]) << LF_TESTMODE_LSB);
      partner.line(1'(i % 2), !(i % 2));
      repeat (4) @(posedge core_clk);
      #1;
      chk("txd", (tms[i / 2] == TM_LOCAL_LOOP) ? 32'h1 : i % 2, {31'h0, txdPin});
      if (tms[i / 2] != TM_REMOTE_LOOP) begin
        chk("rx_line", (i / 2 == 1) ? 1 - i % 2 : i % 2, {31'h0, rxLine});
      end
    end
    partner.line(1'b1, 1'b1);
    // smart card negative acknowledge: plain, inhibited, limited to two
    apb(1'b1, OFF_LINE_FORMAT_CONFIG, 32'(MODE_SMART_T0));
    non_ack_seen("non_ack_seen_pe", 1'b1, 1'b1);
    non_ack_seen("non_ack_seen_ok", 1'b0, 1'b0);
    apb(1'b1, OFF_LINE_FORMAT_CONFIG, 32'(MODE_SMART_T0) | (32'h1 << LF_INHIBIT_NON_ACK_SEEN));
    non_ack_seen("non_ack_seen_inh", 1'b1, 1'b0);
    apb(1'b1, OFF_LINE_FORMAT_CONFIG, 32'(MODE_SMART_T0) | 32'h0220_0000);
    non_ack_seen("lim1", 1'b1, 1'b1);
    stbit("iter0", ST_ITERATION_HIT, 1'b0);
    non_ack_seen("lim2", 1'b1, 1'b1);
    stbit("iter1", ST_ITERATION_HIT, 1'b1);
    non_ack_seen("lim3", 1'b1, 1'b0);
    cmd(CMD_CLEAR_ITERATION);
    stbit("iter_clr", ST_ITERATION_HIT, 1'b0);
    non_ack_seen("lim_again", 1'b1, 1'b1);
    // filter: a low two cycles old, before any sample tick, is held off; a held low passes
    apb(1'b1, OFF_LINE_FORMAT_CONFIG, 32'h1 << LF_IR_FILTER);
    partner.line(1'b0, 1'b1);
    repeat (2) @(posedge core_clk);
    #1;
    chk("filt_hold", 32'h1, {31'h0, rxLine});
    repeat (24) @(posedge core_clk);
    #1;
    chk("filt_pass", 32'h0, {31'h0, rxLine});
    print_verdict();
  end
endmodule : tb_top
